//--- pkg/fsb_defs.svh
`ifndef FSB_DEFS_SVH
`define FSB_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FSB_OFF_CTRL      12'h000
`define FSB_OFF_ZSPEED    12'h004
`define FSB_OFF_DECEL     12'h008
`define FSB_OFF_BRKDLY    12'h00c
`define FSB_OFF_RATED     12'h010
`define FSB_OFF_STATUS    12'h014
`define FSB_OFF_SPEEDCMD  12'h018

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define FSB_CTRL_SEL_LSB  0
`define FSB_CTRL_SEL_MSB  3
`define FSB_CTRL_BSEQ_BIT 4
`define FSB_CTRL_MULTI_BIT 5

// ----------------------------------------
// Selection codes and reset values
// ----------------------------------------
`define FSB_SEL_DISABLED  4'h0
`define FSB_SEL_ENABLED   4'h2
`define FSB_RST_SEL       4'h2
`define FSB_RST_ZSPEED    16'h0032
`define FSB_RST_DECEL_MS  16'h0064
`define FSB_RST_BRKDLY_MS 16'h0000
`define FSB_RST_RATED     16'h0bb8

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSB_CLK_HZ        20000000
`define FSB_MS_NS         1000000
`define FSB_CLK_NS        50
`define FSB_CYC_PER_MS    (`FSB_MS_NS / `FSB_CLK_NS)

`endif

//--- pkg/fsb_pkg.sv
package fsb_pkg;

  typedef enum logic [5:0] {
    FSB_RUN    = 6'h01,
    FSB_DECEL  = 6'h02,
    FSB_ZWAIT  = 6'h04,
    FSB_BDELAY = 6'h08,
    FSB_DBRAKE = 6'h10,
    FSB_OFF    = 6'h20
  } fsb_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } fsb_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic        valid;
  } fsb_wdata_t;

  typedef struct packed {
    logic        servo_on;
    logic        ready_on;
    logic        fstop1_n;
    logic        fstop2_n;
    logic        net_lost;
    logic        sto_n;
    logic        alarm_decel;
    logic        alarm_direct;
    logic        torque_mode;
  } fsb_cmd_t;

endpackage

//--- rtl/fsb_ramp.sv
`timescale 1ns/1ps
`include "fsb_defs.svh"

// Linear speed ramp: drops by rated speed per decel time
module fsb_ramp #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] start_i,
  input  wire logic [W-1:0] rated_i,
  input  wire logic [W-1:0] decel_ms_i,
  output logic      [W-1:0] speed_o,
  output logic              done_o
);

  // ----------------------------------------
  // Fractional accumulator
  // ----------------------------------------
  logic [W-1:0] speed_q;
  logic [39:0]  acc_q;
  logic [39:0]  period;
  logic         step;

  assign period = 40'(decel_ms_i) * 40'(`FSB_CYC_PER_MS);
  assign step   = (acc_q + 40'(rated_i)) >= period;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 40'h0;
    end else if (load_i || !run_i) begin
      acc_q <= 40'h0;
    end else if (step) begin
      acc_q <= acc_q + 40'(rated_i) - period;
    end else begin
      acc_q <= acc_q + 40'(rated_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      speed_q <= '0;
    end else if (load_i) begin
      speed_q <= start_i;
    end else if (run_i && (period == 40'h0)) begin
      speed_q <= '0;
    end else if (run_i && step && speed_q != '0) begin
      speed_q <= speed_q - W'(1);
    end
  end

  assign speed_o = speed_q;
  assign done_o  = (speed_q == '0);

endmodule

//--- rtl/fsb_top.sv
`timescale 1ns/1ps
`include "fsb_defs.svh"

// Operation
// - Stop input two drop starts decel ramp
// - Ramp done, below zero speed: brake
// - Warning flag shown while decelerating
// - Select 0 disabled, 2 enabled, default 2
// - Zero speed level configurable, default 50
// - Decel time constant configurable, default 100ms
// - No forced decel in torque modes
// - Non-decel alarms use own stop
// - Network loss triggers forced decel too
// - Disabled: any alarm uses dynamic brake
// - Brake alarm during ramp aborts ramp
// - Safe torque off drop: immediate brake
// - Release brake interlock at stops
// - Delay power-off after brake interlock drop
// - No delay for non-decel alarms
// - Disabled function: no delay on stops
// - Ready-off skips delay unless select 1
module fsb_top #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire fsb_pkg::fsb_cmd_t cmd_i,
  input  wire logic [W-1:0] speed_cmd_i,
  input  wire logic [W-1:0] speed_meas_i,
  output logic [W-1:0]      speed_cmd_o,
  output logic              power_stage_on_o,
  output logic              dyn_brake_o,
  output logic              brake_interlock_output_o,
  output logic              forced_stop_warning_o,
  output logic              zero_speed_detect_o
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [3:0]   sel_q;
  logic         bseq_q;
  logic         multi_q;
  logic [W-1:0] zspeed_q;
  logic [W-1:0] decel_q;
  logic [W-1:0] brkdly_q;
  logic [W-1:0] rated_q;
  logic         aw_hold_q;
  logic         w_hold_q;
  logic [11:0]  awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         wr_go;
  logic         wr_ok;
  logic         rd_ok;
  logic [31:0]  rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a == `FSB_OFF_CTRL) || (a == `FSB_OFF_ZSPEED) || (a == `FSB_OFF_DECEL) ||
           (a == `FSB_OFF_BRKDLY) || (a == `FSB_OFF_RATED) || (a == `FSB_OFF_STATUS) ||
           (a == `FSB_OFF_SPEEDCMD);
  endfunction

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ok = mapped(awaddr_q) && (awaddr_q != `FSB_OFF_STATUS) &&
                 (awaddr_q != `FSB_OFF_SPEEDCMD);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_q     <= 1'b0;
      awaddr_q      <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr[11:0];
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      w_hold_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  assign ctrl_word = {26'h0, multi_q, bseq_q, sel_q};
  assign ctrl_new  = merge(ctrl_word, wdata_q, wstrb_q);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q    <= `FSB_RST_SEL;
      bseq_q   <= 1'b0;
      multi_q  <= 1'b0;
      zspeed_q <= W'(`FSB_RST_ZSPEED);
      decel_q  <= W'(`FSB_RST_DECEL_MS);
      brkdly_q <= W'(`FSB_RST_BRKDLY_MS);
      rated_q  <= W'(`FSB_RST_RATED);
    end else if (wr_go && wr_ok) begin
      if (awaddr_q == `FSB_OFF_CTRL) begin
        // Only the two documented selection codes are taken
        if (ctrl_new[`FSB_CTRL_SEL_MSB:`FSB_CTRL_SEL_LSB] == `FSB_SEL_DISABLED ||
            ctrl_new[`FSB_CTRL_SEL_MSB:`FSB_CTRL_SEL_LSB] == `FSB_SEL_ENABLED) begin
          sel_q <= ctrl_new[`FSB_CTRL_SEL_MSB:`FSB_CTRL_SEL_LSB];
        end
        bseq_q  <= ctrl_new[`FSB_CTRL_BSEQ_BIT];
        multi_q <= ctrl_new[`FSB_CTRL_MULTI_BIT];
      end else if (awaddr_q == `FSB_OFF_ZSPEED) begin
        zspeed_q <= W'(merge(32'(zspeed_q), wdata_q, wstrb_q));
      end else if (awaddr_q == `FSB_OFF_DECEL) begin
        decel_q <= W'(merge(32'(decel_q), wdata_q, wstrb_q));
      end else if (awaddr_q == `FSB_OFF_BRKDLY) begin
        brkdly_q <= W'(merge(32'(brkdly_q), wdata_q, wstrb_q));
      end else begin
        rated_q <= W'(merge(32'(rated_q), wdata_q, wstrb_q));
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  fsb_pkg::fsb_state_t state_q;
  logic [W-1:0]        speed_q;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr[11:0] == `FSB_OFF_CTRL) begin
      rd_word = ctrl_word;
    end else if (s_axi_araddr[11:0] == `FSB_OFF_ZSPEED) begin
      rd_word = 32'(zspeed_q);
    end else if (s_axi_araddr[11:0] == `FSB_OFF_DECEL) begin
      rd_word = 32'(decel_q);
    end else if (s_axi_araddr[11:0] == `FSB_OFF_BRKDLY) begin
      rd_word = 32'(brkdly_q);
    end else if (s_axi_araddr[11:0] == `FSB_OFF_RATED) begin
      rd_word = 32'(rated_q);
    end else if (s_axi_araddr[11:0] == `FSB_OFF_STATUS) begin
      rd_word = {20'h0, zero_speed_detect_o, forced_stop_warning_o, brake_interlock_output_o,
                 dyn_brake_o, power_stage_on_o, 1'b0, state_q};
    end else if (s_axi_araddr[11:0] == `FSB_OFF_SPEEDCMD) begin
      rd_word = 32'(speed_cmd_o);
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Stop causes
  // ----------------------------------------
  logic enabled;
  logic stop_in;
  logic decel_cause;
  logic direct_cause;
  logic soft_off;
  logic zero_spd;
  logic ramp_done;
  logic ramp_load;
  logic ramp_run;
  logic [W-1:0] ramp_speed;
  logic [31:0]  dly_q;
  logic [31:0]  dly_cyc;

  assign enabled  = (sel_q == `FSB_SEL_ENABLED);
  // Disabled selects the first stop input, enabled the second
  assign stop_in  = enabled ? !cmd_i.fstop2_n : !cmd_i.fstop1_n;
  assign zero_spd = (speed_meas_i < zspeed_q);
  assign decel_cause = enabled && !cmd_i.torque_mode &&
                       (stop_in || cmd_i.net_lost || cmd_i.alarm_decel);
  // Torque mode and disabled function fall to the dynamic brake at once
  assign direct_cause = !cmd_i.sto_n || cmd_i.alarm_direct ||
                        ((stop_in || cmd_i.net_lost || cmd_i.alarm_decel) &&
                         (!enabled || cmd_i.torque_mode));
  assign soft_off = !cmd_i.servo_on || (!cmd_i.ready_on && bseq_q);
  assign dly_cyc  = 32'(brkdly_q) * 32'(`FSB_CYC_PER_MS);

  assign ramp_load = (state_q == fsb_pkg::FSB_RUN) && decel_cause && !direct_cause;
  assign ramp_run  = (state_q == fsb_pkg::FSB_DECEL);

  fsb_ramp #(
    .W (W)
  ) u_ramp (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .load_i     (ramp_load),
    .run_i      (ramp_run),
    .start_i    (speed_cmd_i),
    .rated_i    (rated_q),
    .decel_ms_i (decel_q),
    .speed_o    (ramp_speed),
    .done_o     (ramp_done)
  );

  // ----------------------------------------
  // Stop sequencer
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= fsb_pkg::FSB_OFF;
      dly_q   <= 32'h0;
    end else begin
      case (state_q)
        fsb_pkg::FSB_RUN: begin
          dly_q <= 32'h0;
          if (direct_cause || !cmd_i.ready_on && !bseq_q) begin
            state_q <= fsb_pkg::FSB_DBRAKE;
          end else if (decel_cause) begin
            state_q <= fsb_pkg::FSB_DECEL;
          end else if (soft_off) begin
            state_q <= fsb_pkg::FSB_BDELAY;
          end
        end
        fsb_pkg::FSB_DECEL: begin
          if (direct_cause) begin
            state_q <= fsb_pkg::FSB_DBRAKE;
          end else if (ramp_done) begin
            state_q <= fsb_pkg::FSB_ZWAIT;
          end
        end
        fsb_pkg::FSB_ZWAIT: begin
          if (direct_cause) begin
            state_q <= fsb_pkg::FSB_DBRAKE;
          end else if (zero_spd) begin
            state_q <= fsb_pkg::FSB_BDELAY;
          end
        end
        fsb_pkg::FSB_BDELAY: begin
          dly_q <= dly_q + 32'h1;
          if (direct_cause || dly_q >= dly_cyc) begin
            state_q <= fsb_pkg::FSB_DBRAKE;
          end
        end
        fsb_pkg::FSB_DBRAKE: begin
          if (speed_meas_i < zspeed_q || !cmd_i.servo_on) begin
            state_q <= fsb_pkg::FSB_OFF;
          end
        end
        default: begin
          // Restart only when every stop cause has gone
          if (cmd_i.servo_on && cmd_i.ready_on && !stop_in && !cmd_i.net_lost &&
              cmd_i.sto_n && !cmd_i.alarm_decel && !cmd_i.alarm_direct) begin
            state_q <= fsb_pkg::FSB_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      speed_q                  <= '0;
      power_stage_on_o         <= 1'b0;
      dyn_brake_o              <= 1'b1;
      brake_interlock_output_o <= 1'b0;
      forced_stop_warning_o    <= 1'b0;
      zero_speed_detect_o      <= 1'b0;
    end else begin
      zero_speed_detect_o <= zero_spd;
      forced_stop_warning_o <= (state_q == fsb_pkg::FSB_DECEL) ||
                               (state_q == fsb_pkg::FSB_ZWAIT);
      speed_q <= (state_q == fsb_pkg::FSB_RUN) ? speed_cmd_i :
                 ramp_run ? ramp_speed : '0;
      power_stage_on_o <= (state_q == fsb_pkg::FSB_RUN) || (state_q == fsb_pkg::FSB_DECEL) ||
                          (state_q == fsb_pkg::FSB_ZWAIT) ||
                          (state_q == fsb_pkg::FSB_BDELAY);
      dyn_brake_o <= (state_q == fsb_pkg::FSB_DBRAKE) || (state_q == fsb_pkg::FSB_OFF);
      brake_interlock_output_o <= (state_q == fsb_pkg::FSB_RUN) ||
                                  (state_q == fsb_pkg::FSB_DECEL) ||
                                  (state_q == fsb_pkg::FSB_ZWAIT);
    end
  end

  assign speed_cmd_o = speed_q;

endmodule

//--- tb/fsb_monitor.sv
`timescale 1ns/1ps

module fsb_monitor #(
  parameter int W      = 16,
  parameter int ZLEVEL = 50
) (
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire fsb_pkg::fsb_cmd_t cmd_i,
  input wire logic [W-1:0]      speed_meas_i,
  input wire logic [W-1:0]      speed_cmd_o,
  input wire logic              power_stage_on_o,
  input wire logic              dyn_brake_o,
  input wire logic              brake_interlock_output_o,
  input wire logic              forced_stop_warning_o,
  input wire logic              zero_speed_detect_o
);
  default clocking mon_cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Stop sequencing checks
  // ----------------------------------------
  sto_brake_a: assert property ($fell(cmd_i.sto_n) && power_stage_on_o |->
    ##[1:4] (dyn_brake_o && !power_stage_on_o)) else $error("safe torque off did not brake");
  direct_alarm_a: assert property ($rose(cmd_i.alarm_direct) && power_stage_on_o |->
    ##[1:4] !power_stage_on_o) else $error("direct alarm did not cut power");
  brake_first_a: assert property ($fell(power_stage_on_o) |->
    !brake_interlock_output_o && dyn_brake_o) else $error("power cut without brakes");
  interlock_power_a: assert property (brake_interlock_output_o |->
    power_stage_on_o) else $error("holding brake released without power");
  warn_power_a: assert property (forced_stop_warning_o |->
    power_stage_on_o && !dyn_brake_o) else $error("warning outside ramp");
  torque_nodecel_a: assert property ($rose(forced_stop_warning_o) |->
    !$past(cmd_i.torque_mode, 2)) else $error("ramp started in torque mode");
  ramp_step_a: assert property (forced_stop_warning_o && $past(forced_stop_warning_o) |->
    ({1'b0, speed_cmd_o} <= {1'b0, $past(speed_cmd_o)})
    && ({1'b0, speed_cmd_o} + 17'h1 >= {1'b0, $past(speed_cmd_o)}))
    else $error("ramp step wrong");
  zero_level_a: assert property (!$past(rst_i) |->
    zero_speed_detect_o == ($past(speed_meas_i) < ZLEVEL)) else $error("zero speed flag wrong");

  cover property ($rose(forced_stop_warning_o));
  cover property ($fell(cmd_i.sto_n) && power_stage_on_o);
  cover property ($fell(brake_interlock_output_o) && power_stage_on_o);
endmodule

bind fsb_top fsb_monitor #(.W(W)) mon_u (
  .clock_i                  (clock_i),
  .rst_i                    (rst_i),
  .cmd_i                    (cmd_i),
  .speed_meas_i             (speed_meas_i),
  .speed_cmd_o              (speed_cmd_o),
  .power_stage_on_o         (power_stage_on_o),
  .dyn_brake_o              (dyn_brake_o),
  .brake_interlock_output_o (brake_interlock_output_o),
  .forced_stop_warning_o    (forced_stop_warning_o),
  .zero_speed_detect_o      (zero_speed_detect_o)
);

//--- tb/fsb_motor.sv
`timescale 1ns/1ps

// Motor: tracks the command while powered, otherwise slows one unit a cycle
module fsb_motor #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] speed_cmd_i,
  input  wire logic         power_i,
  output logic      [W-1:0] speed_meas_o
);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      speed_meas_o <= '0;
    end else if (power_i) begin
      speed_meas_o <= speed_cmd_i;
    end else if (speed_meas_o != '0) begin
      speed_meas_o <= speed_meas_o - 1'b1;
    end
  end
endmodule

//--- tb/tb_forced_stop_brake_sequencer.sv
`timescale 1ns/1ps
`include "fsb_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module tb_forced_stop_brake_sequencer;
  logic              clock_i, rst_i;
  logic [31:0]       awaddr, wdata, araddr, rdata;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp, resp;
  fsb_pkg::fsb_cmd_t cmd_i, ok_c, c, a;
  logic [15:0]       spd_in, spd_meas, spd_out;
  logic              pwr, dbrk, intlk, warn, zero_speed_detect;
  int                errors, compares, cycles, ramp_t;

  fsb_top #(.W(16)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_i(cmd_i), .speed_cmd_i(spd_in), .speed_meas_i(spd_meas), .speed_cmd_o(spd_out),
    .power_stage_on_o(pwr), .dyn_brake_o(dbrk), .brake_interlock_output_o(intlk),
    .forced_stop_warning_o(warn), .zero_speed_detect_o(zero_speed_detect));

  fsb_motor #(.W(16)) motor_u (
    .clock_i(clock_i), .rst_i(rst_i), .speed_cmd_i(spd_out), .power_i(pwr),
    .speed_meas_o(spd_meas));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d);
    awaddr <= {20'h0, ad}; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] ad, output logic [31:0] d);
    araddr <= {20'h0, ad}; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        break;
      end
    end
  endtask

  // ----------------------------------------
  // Stop sequences
  // ----------------------------------------
  task automatic bring_up();
    cmd_i <= ok_c;
    @(posedge clock_i);
    while (pwr !== 1'b1) @(posedge clock_i);
    repeat (10) @(posedge clock_i);
    `CHK("zero speed flag", 1'b0, zero_speed_detect)
  endtask

  // Applies a stop cause, optionally a second cause mid-ramp, then measures
  task automatic run_stop(input fsb_pkg::fsb_cmd_t sc, ab, input logic ew, ed);
    int n, gap, zt;
    logic w;
    n = 0; gap = 0; zt = 0; w = 1'b0;
    cmd_i <= sc;
    while (pwr !== 1'b0) begin
      @(posedge clock_i);
      n++;
      if (n == 100) cmd_i <= ab;
      if (warn === 1'b1) w = 1'b1;
      if (intlk === 1'b0) gap++;
      if (spd_out === 16'h0 && zt == 0) zt = n;
    end
    ramp_t = zt;
    `CHK("warning seen", ew, w)
    `CHK("shutoff delay", 1'b1, ed ? (gap >= 19998 && gap <= 20006) : (gap <= 3))
    repeat (2) @(posedge clock_i);
    `CHK("dynamic brake", 1'b1, dbrk)
    `CHK("brake interlock", 1'b0, intlk)
    bring_up();
  endtask

  initial begin
    logic [31:0] d;
    errors = 0; compares = 0; cycles = 0;
    rst_i = 1'b1; awaddr = '0; awvalid = 0; wdata = '0; wvalid = 0; bready = 0;
    araddr = '0; arvalid = 0; rready = 0; spd_in = 16'h003c;
    ok_c = '{servo_on: 1, ready_on: 1, fstop1_n: 1, fstop2_n: 1, net_lost: 0, sto_n: 1,
             alarm_decel: 0, alarm_direct: 0, torque_mode: 0};
    cmd_i = ok_c;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    axi_rd(`FSB_OFF_CTRL, d);
    `CHK("select", `FSB_RST_SEL, d[3:0])
    `CHK("brake seq select", 1'b0, d[4])
    axi_rd(`FSB_OFF_ZSPEED, d);
    `CHK("zero level", 32'h32, d)
    axi_rd(`FSB_OFF_DECEL, d);
    `CHK("decel time", 32'h64, d)
    axi_rd(12'h020, d);
    `CHK("unmapped resp", 2'b10, resp)
    axi_wr(`FSB_OFF_STATUS, 32'h0);
    `CHK("read-only resp", 2'b10, resp)
    axi_wr(`FSB_OFF_CTRL, 32'h1);
    axi_rd(`FSB_OFF_CTRL, d);
    `CHK("invalid select", 4'h2, d[3:0])
    axi_wr(`FSB_OFF_DECEL, 32'h1);
    axi_wr(`FSB_OFF_BRKDLY, 32'h1);
    bring_up();
    axi_rd(`FSB_OFF_STATUS, d);
    `CHK("status", 32'h0000_0281, d)
    axi_rd(`FSB_OFF_SPEEDCMD, d);
    `CHK("speed command", 32'h0000_003c, d)
    // Stop input drops while servo-on and ready-on stay high
    c = ok_c; c.fstop2_n = 1'b0; run_stop(c, c, 1'b1, 1'b1);
    `CHK("ramp time", 1'b1, ramp_t >= 60 * `FSB_CYC_PER_MS / 3000 && ramp_t <= 406)
    c = ok_c; c.net_lost = 1'b1; a = c; a.sto_n = 1'b0; run_stop(c, a, 1'b1, 1'b0);
    c = ok_c; c.alarm_decel = 1'b1; a = c; a.alarm_direct = 1'b1;
    run_stop(c, a, 1'b1, 1'b0);
    c = ok_c; c.alarm_direct = 1'b1; run_stop(c, c, 1'b0, 1'b0);
    c = ok_c; c.torque_mode = 1'b1; c.fstop2_n = 1'b0; run_stop(c, c, 1'b0, 1'b0);
    c = ok_c; c.ready_on = 1'b0; run_stop(c, c, 1'b0, 1'b0);
    c = ok_c; c.servo_on = 1'b0; run_stop(c, c, 1'b0, 1'b1);
    axi_wr(`FSB_OFF_CTRL, 32'h32);
    axi_rd(`FSB_OFF_CTRL, d);
    `CHK("multi select", 1'b1, d[5])
    `CHK("brake seq select", 1'b1, d[4])
    c = ok_c; c.ready_on = 1'b0; run_stop(c, c, 1'b0, 1'b1);
    axi_wr(`FSB_OFF_CTRL, 32'h0);
    axi_rd(`FSB_OFF_CTRL, d);
    `CHK("select", `FSB_SEL_DISABLED, d[3:0])
    c = ok_c; c.fstop1_n = 1'b0; run_stop(c, c, 1'b0, 1'b0);
    print_verdict();
  end
endmodule
